// File: rtl/aoc_pkg.sv
// constants, states and the code conversion for the converter output control
// assumes a 200 MHz control clock and a free sample clock on the link side
// Overview of operation
// - edge select high: output words change with forwarded clock rising
// - edge select low: output words change with forwarded clock falling
// - interleave mode routes one input to both cores
// - interleave: one core samples rising edge, other falling edge
// - interleave gives 1:4 demux at twice the input clock rate
// - pin mode: floating delay pin enables interleave from channel one
// - pin-mode interleave always uses the short trim delay
// - register mode: either input may feed interleave
// - one input powers all down, the other only channel two
// - powered-down channel data outputs are high impedance
// - power-down waits for a running trim to finish
// - power-down high at power up holds off the first trim
// - trim requests are ignored while powered down
// - double rate: a word each clock edge, clock at quarter rate
// - output codes are offset binary
// - internal reset runs from the sample clock; analog waits for it
// - trim active high during trim, data and clock outputs off
package aoc_pkg;
    localparam logic [3:0] IE_ADDR = 4'hd;
    localparam logic [15:0] IE_RESET = 16'h0000;
    localparam int IE_DES_EN_BIT = 15;
    localparam int IE_PHASE_AUTO_BIT = 14;
    localparam int IE_SRC_Q_BIT = 13;
    localparam int ST_CAL_BIT = 1;
    localparam int ST_DOWN_BIT = 0;
    localparam logic [6:0] REQ_HOLD_CYC = 7'd80;
    localparam int CNT_W = 24;
    localparam logic [23:0] CAL_RUN_CYC = 24'h000fa0;
    localparam logic [23:0] DLY_SHORT_CYC = 24'h000400;
    localparam int CTL_DES = 0;
    localparam int CTL_SRCQ = 1;
    localparam int CTL_IOFF = 2;
    localparam int CTL_QOFF = 3;
    localparam int CTL_COFF = 4;
    localparam int CTL_W = 5;
    typedef enum logic [2:0] {ST_BOOT, ST_DELAY, ST_CAL, ST_RUN, ST_DOWN} aoc_state_t;
    function automatic logic [7:0] aoc_obin(input logic [7:0] s);
        return {~s[7], s[6:0]};
    endfunction
endpackage

// File: rtl/aoc_top.sv
// converter output mode, power-down and trim sequencing control
// assumes pins are asynchronous; sample clock may stand still before start
`timescale 1ns/10ps
module aoc_pin_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_reg, s2_reg, s3_reg, q_next;
    always_comb begin
        q_next = (s2_reg == s3_reg) ? s3_reg : q_o;
    end
    always_ff @(posedge clk_i) begin
        s1_reg <= d_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (!rst_n_i) begin
            q_o <= 1'b0;
        end else begin
            q_o <= q_next;
        end
    end
endmodule // aoc_pin_sync

module aoc_top import aoc_pkg::*; #(
    parameter int CAL_DLY_LONG_CYC = 1048576
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic SAMPLE_CLK_I,
    input wire logic OUTPUT_EDGE_SELECT_I,
    input wire logic DDR_SELECT_I,
    input wire logic OUTPUT_SWING_SELECT_I,
    input wire logic FULL_POWERDOWN_INPUT_I,
    input wire logic SECOND_CHANNEL_SLEEP_INPUT_I,
    input wire logic SELFTRIM_REQUEST_I,
    input wire logic SELFTRIM_DELAY_SELECT_I,
    input wire logic DELAY_PIN_FLOAT_I,
    input wire logic EXT_CTRL_MODE_I,
    input wire logic REG_WR_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    output logic [15:0] REG_RDATA_O,
    input wire logic [7:0] AIN_I_I,
    input wire logic [7:0] AIN_Q_I,
    output logic [7:0] DATA_I_O,
    output logic [7:0] DATA_ID_O,
    output logic [7:0] DATA_Q_O,
    output logic [7:0] DATA_QD_O,
    output logic DATA_I_OE_O,
    output logic DATA_Q_OE_O,
    output logic FORWARDED_OUTPUT_CLOCK_O,
    output logic FORWARDED_OUTPUT_CLOCK_OE_O,
    output logic SELFTRIM_ACTIVE_O,
    output logic OUTPUT_SWING_O,
    output logic ANALOG_ON_O
);
    // control domain
    logic pd_s, sleep_s, dly_s, float_s, ext_s;
    logic alive1_reg, alive2_reg;
    logic tg1_reg, tg2_reg, tg3_reg, cal_evt;
    aoc_state_t st_reg, st_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [15:0] ie_reg, ie_next, rd_next;
    logic [CTL_W-1:0] ctl_reg, ctl_next;
    logic act_next, on_next, des_c, srcq_c;
    logic [CNT_W-1:0] dly_len;
    // link domain
    logic lrst1_reg, lrst_n;
    logic edge_l, ddr_l, req_l;
    logic [CTL_W-1:0] lc1_reg, lc2_reg;
    logic alive_reg, ph_reg, ph_next, fclk_next, upd;
    logic [7:0] fall_reg, a_reg, b_reg, ap_reg, bp_reg, a_next, b_next;
    logic [6:0] lowc_reg, lowc_next, highc_reg, highc_next;
    logic tgl_reg, tgl_next;

    aoc_pin_sync u_pd (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I),
        .d_i(FULL_POWERDOWN_INPUT_I), .q_o(pd_s));
    aoc_pin_sync u_sleep (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I),
        .d_i(SECOND_CHANNEL_SLEEP_INPUT_I), .q_o(sleep_s));
    aoc_pin_sync u_swing (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I),
        .d_i(OUTPUT_SWING_SELECT_I), .q_o(OUTPUT_SWING_O));
    aoc_pin_sync u_dly (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I),
        .d_i(SELFTRIM_DELAY_SELECT_I), .q_o(dly_s));
    aoc_pin_sync u_float (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I),
        .d_i(DELAY_PIN_FLOAT_I), .q_o(float_s));
    aoc_pin_sync u_ext (.clk_i(CORE_CLK_I), .rst_n_i(RST_N_I),
        .d_i(EXT_CTRL_MODE_I), .q_o(ext_s));

    assign cal_evt = tg2_reg ^ tg3_reg;
    assign des_c = ext_s ? ie_reg[IE_DES_EN_BIT] : float_s;
    assign srcq_c = ext_s & ie_reg[IE_SRC_Q_BIT];
    assign dly_len = (ext_s || float_s || !dly_s) ? DLY_SHORT_CYC
                                                   : CNT_W'(CAL_DLY_LONG_CYC);

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            ST_BOOT: begin
                if (alive2_reg && !pd_s) begin
                    st_next = ST_DELAY;
                    cnt_next = dly_len;
                end
            end
            ST_DELAY: begin
                if (!pd_s) begin
                    if (cnt_reg == '0) begin
                        st_next = ST_CAL;
                        cnt_next = CAL_RUN_CYC;
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
            end
            ST_CAL: begin
                if (cnt_reg == '0) begin
                    st_next = pd_s ? ST_DOWN : ST_RUN;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_RUN: begin
                if (pd_s) begin
                    st_next = ST_DOWN;
                end else if (cal_evt) begin
                    st_next = ST_CAL;
                    cnt_next = CAL_RUN_CYC;
                end
            end
            ST_DOWN: begin
                if (!pd_s) begin
                    st_next = ST_RUN;
                end
            end
            default: begin
                st_next = ST_BOOT;
            end
        endcase
    end

    always_comb begin
        ie_next = ie_reg;
        if (REG_WR_I && REG_ADDR_I == IE_ADDR) begin
            ie_next = REG_WDATA_I;
        end
        ie_next[ST_CAL_BIT] = 1'b0;
        ie_next[ST_DOWN_BIT] = 1'b0;
        rd_next = '0;
        if (REG_ADDR_I == IE_ADDR) begin
            rd_next = ie_reg;
            rd_next[ST_CAL_BIT] = (st_reg == ST_CAL);
            rd_next[ST_DOWN_BIT] = (st_reg == ST_DOWN);
        end
        act_next = (st_next == ST_CAL);
        on_next = alive2_reg;
        ctl_next = '0;
        ctl_next[CTL_DES] = des_c;
        ctl_next[CTL_SRCQ] = srcq_c;
        ctl_next[CTL_IOFF] = (st_next != ST_RUN);
        ctl_next[CTL_QOFF] = (st_next != ST_RUN) || sleep_s;
        ctl_next[CTL_COFF] = (st_next != ST_RUN);
    end

    always_ff @(posedge CORE_CLK_I) begin
        alive1_reg <= alive_reg;
        alive2_reg <= alive1_reg;
        tg1_reg <= tgl_reg;
        tg2_reg <= tg1_reg;
        if (!RST_N_I) begin
            tg3_reg <= 1'b0;
            st_reg <= ST_BOOT;
            cnt_reg <= '0;
            ie_reg <= IE_RESET;
            REG_RDATA_O <= '0;
            SELFTRIM_ACTIVE_O <= 1'b0;
            ANALOG_ON_O <= 1'b0;
            ctl_reg <= 5'h1c;
        end else begin
            tg3_reg <= tg2_reg;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            ie_reg <= ie_next;
            REG_RDATA_O <= rd_next;
            SELFTRIM_ACTIVE_O <= act_next;
            ANALOG_ON_O <= on_next;
            ctl_reg <= ctl_next;
        end
    end

    // link reset needs the sample clock to run
    always_ff @(posedge SAMPLE_CLK_I) begin
        lrst1_reg <= RST_N_I;
        lrst_n <= lrst1_reg;
        lc1_reg <= ctl_reg;
        lc2_reg <= lc1_reg;
    end

    aoc_pin_sync u_edge (.clk_i(SAMPLE_CLK_I), .rst_n_i(lrst_n),
        .d_i(OUTPUT_EDGE_SELECT_I), .q_o(edge_l));
    aoc_pin_sync u_ddr (.clk_i(SAMPLE_CLK_I), .rst_n_i(lrst_n),
        .d_i(DDR_SELECT_I), .q_o(ddr_l));
    aoc_pin_sync u_req (.clk_i(SAMPLE_CLK_I), .rst_n_i(lrst_n),
        .d_i(SELFTRIM_REQUEST_I), .q_o(req_l));

    // second core on the falling edge
    always_ff @(negedge SAMPLE_CLK_I) begin
        fall_reg <= lc2_reg[CTL_SRCQ] ? AIN_Q_I : AIN_I_I;
    end

    always_comb begin
        a_next = aoc_obin(lc2_reg[CTL_SRCQ] && lc2_reg[CTL_DES] ? AIN_Q_I : AIN_I_I);
        b_next = aoc_obin(lc2_reg[CTL_DES] ? fall_reg : AIN_Q_I);
        // single rate clock at half rate
        // double rate clock at quarter rate
        ph_next = ~ph_reg;
        fclk_next = (ddr_l && !ph_reg) ? FORWARDED_OUTPUT_CLOCK_O : ~FORWARDED_OUTPUT_CLOCK_O;
        upd = ddr_l ? ph_reg : (fclk_next == edge_l);
        // trim request must be low 80 then high 80 cycles
        lowc_next = lowc_reg;
        highc_next = '0;
        tgl_next = tgl_reg;
        if (!req_l) begin
            if (lowc_reg != REQ_HOLD_CYC) begin
                lowc_next = lowc_reg + 1'b1;
            end
        end else if (lowc_reg == REQ_HOLD_CYC) begin
            highc_next = highc_reg + 1'b1;
            if (highc_next == REQ_HOLD_CYC) begin
                tgl_next = ~tgl_reg;
                lowc_next = '0;
                highc_next = '0;
            end
        end
    end

    always_ff @(posedge SAMPLE_CLK_I) begin
        if (!lrst_n) begin
            alive_reg <= 1'b0;
            ph_reg <= 1'b0;
            FORWARDED_OUTPUT_CLOCK_O <= 1'b0;
            a_reg <= '0;
            b_reg <= '0;
            ap_reg <= '0;
            bp_reg <= '0;
            DATA_I_O <= '0;
            DATA_ID_O <= '0;
            DATA_Q_O <= '0;
            DATA_QD_O <= '0;
            DATA_I_OE_O <= 1'b0;
            DATA_Q_OE_O <= 1'b0;
            FORWARDED_OUTPUT_CLOCK_OE_O <= 1'b0;
            lowc_reg <= '0;
            highc_reg <= '0;
            tgl_reg <= 1'b0;
        end else begin
            alive_reg <= 1'b1;
            ph_reg <= ph_next;
            FORWARDED_OUTPUT_CLOCK_O <= fclk_next;
            a_reg <= a_next;
            b_reg <= b_next;
            ap_reg <= a_reg;
            bp_reg <= b_reg;
            // two words per core per update
            if (upd) begin
                DATA_I_O <= ap_reg;
                DATA_ID_O <= a_reg;
                DATA_Q_O <= bp_reg;
                DATA_QD_O <= b_reg;
            end
            DATA_I_OE_O <= !lc2_reg[CTL_IOFF];
            DATA_Q_OE_O <= !lc2_reg[CTL_QOFF];
            FORWARDED_OUTPUT_CLOCK_OE_O <= !lc2_reg[CTL_COFF];
            lowc_reg <= lowc_next;
            highc_reg <= highc_next;
            tgl_reg <= tgl_next;
        end
    end

    // link checks wait for the first running edge: the reset edge itself launches nothing
    rise_update_a: assert property (@(posedge SAMPLE_CLK_I) disable iff (!alive_reg)
        (!$past(ddr_l) && $past(edge_l) && $changed(DATA_I_O))
        |-> $rose(FORWARDED_OUTPUT_CLOCK_O))
        else $error("data changed off the rising forwarded edge");
    fall_update_a: assert property (@(posedge SAMPLE_CLK_I) disable iff (!alive_reg)
        (!$past(ddr_l) && !$past(edge_l) && $changed(DATA_I_O))
        |-> $fell(FORWARDED_OUTPUT_CLOCK_O))
        else $error("data changed off the falling forwarded edge");
    sdr_clock_a: assert property (@(posedge SAMPLE_CLK_I) disable iff (!alive_reg)
        (!ddr_l ##1 !ddr_l) |-> (FORWARDED_OUTPUT_CLOCK_O != $past(FORWARDED_OUTPUT_CLOCK_O)))
        else $error("single rate clock not at half rate");
    ddr_clock_a: assert property (@(posedge SAMPLE_CLK_I) disable iff (!alive_reg)
        ($past(ddr_l) && ddr_l && $changed(FORWARDED_OUTPUT_CLOCK_O)) ##1 ddr_l
        |-> $stable(FORWARDED_OUTPUT_CLOCK_O))
        else $error("double rate clock not at quarter rate");
    offset_code_a: assert property (@(posedge SAMPLE_CLK_I) disable iff (!alive_reg)
        (AIN_I_I == 8'h00 && !lc2_reg[CTL_DES]) |=> (a_reg == 8'h80))
        else $error("mid-scale input not coded 128");
    data_float_a: assert property (@(posedge SAMPLE_CLK_I) disable iff (!alive_reg)
        lc2_reg[CTL_IOFF] |=> !DATA_I_OE_O && !FORWARDED_OUTPUT_CLOCK_OE_O)
        else $error("outputs driven while off");
    trim_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (st_reg == ST_CAL) |-> SELFTRIM_ACTIVE_O && ctl_reg[CTL_COFF])
        else $error("trim active not shown");
    trim_finish_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (st_reg == ST_CAL && cnt_reg != '0) |=> (st_reg == ST_CAL))
        else $error("trim cut short");
    down_ignore_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (st_reg == ST_DOWN) |=> (st_reg != ST_CAL))
        else $error("trim started while down");
    boot_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (st_reg == ST_BOOT && pd_s) ##1 pd_s |-> (st_reg == ST_BOOT))
        else $error("first trim not held by power-down");
endmodule // aoc_top

// File: sim/aoc_capture_model.sv
// receiving capture logic model for the converter output buses
// assumes forwarded clock and data leave one sample clock domain together
`timescale 1ns/10ps
module aoc_capture_model (
    input wire logic sample_clk_i,
    input wire logic fclk_i,
    input wire logic oe_i,
    input wire logic edge_sel_i,
    input wire logic ddr_i,
    input wire logic [7:0] data_i_i,
    input wire logic [7:0] data_q_i,
    output logic [7:0] cap_i_o,
    output logic [7:0] cap_q_o,
    output int n_got_o,
    output int n_bad_o,
    output int n_tog_o,
    output int n_smp_o
);
    int flush_cnt = 0;
    logic prev_clk = 1'b0;
    logic prev_oe = 1'b0;
    logic [7:0] prev_data = 8'h00;
    initial begin
        cap_i_o = 8'h00;
        cap_q_o = 8'h00;
        n_got_o = 0;
        n_bad_o = 0;
        n_tog_o = 0;
        n_smp_o = 0;
    end
    always @(negedge oe_i) flush_cnt = 0;
    always @(fclk_i) begin
        n_tog_o = n_tog_o + 1;
        #1;
        if (oe_i === 1'b1 && (ddr_i || fclk_i != edge_sel_i)) begin
            flush_cnt = flush_cnt + 1;
            // the first words after enable hold no samples
            if (flush_cnt > 8) begin
                cap_i_o = data_i_i;
                cap_q_o = data_q_i;
                n_got_o = n_got_o + 1;
            end
        end
    end
    // data moves only on the chosen edge, or on either edge at double rate
    always @(sample_clk_i) begin
        #1;
        if (sample_clk_i) n_smp_o = n_smp_o + 1;
        if (oe_i === 1'b1 && prev_oe === 1'b1 && data_i_i !== prev_data) begin
            if (fclk_i === prev_clk || (!ddr_i && fclk_i !== edge_sel_i)) n_bad_o = n_bad_o + 1;
        end
        prev_clk = fclk_i;
        prev_oe = oe_i;
        prev_data = data_i_i;
    end
endmodule // aoc_capture_model

// File: sim/aoc_top_tb.sv
// self-checking bench for aoc_top: boot, registers, output modes, power-down
// assumes the capture model reports each accepted word pair of the I and Q buses
`timescale 1ns/10ps
module aoc_top_tb import aoc_pkg::*;;
    logic clk = 1'b0, smp_clk = 1'b0, rst_n = 1'b0, edge_sel = 1'b1, ddr = 1'b0;
    logic swing = 1'b1, pd = 1'b0, sleep = 1'b0, req = 1'b0, dsel = 1'b1, flt = 1'b0;
    logic ext = 1'b0, wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [7:0] ain_i = 8'h00, ain_q = 8'h00, d_i, d_id, d_q, d_qd, cap_i, cap_q, rv;
    logic oe_i, oe_q, fclk, fclk_oe, st_act, swing_o, an_on;
    int n_errors = 0, checks = 0, n_trim = 0, cnt, t, n_got, n_bad, n_tog, n_smp;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [7:0] tv[4] = '{8'h7f, 8'h80, 8'h00, 8'h5a};
    always #2.5 clk = ~clk;
    initial begin
        #1.3;
        forever #3 smp_clk = ~smp_clk;
    end
    aoc_top #(.CAL_DLY_LONG_CYC(64)) i_aoc_top (.CORE_CLK_I(clk), .RST_N_I(rst_n),
        .SAMPLE_CLK_I(smp_clk), .OUTPUT_EDGE_SELECT_I(edge_sel), .DDR_SELECT_I(ddr),
        .OUTPUT_SWING_SELECT_I(swing), .FULL_POWERDOWN_INPUT_I(pd),
        .SECOND_CHANNEL_SLEEP_INPUT_I(sleep), .SELFTRIM_REQUEST_I(req),
        .SELFTRIM_DELAY_SELECT_I(dsel), .DELAY_PIN_FLOAT_I(flt), .EXT_CTRL_MODE_I(ext),
        .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .AIN_I_I(ain_i), .AIN_Q_I(ain_q), .DATA_I_O(d_i), .DATA_ID_O(d_id), .DATA_Q_O(d_q),
        .DATA_QD_O(d_qd), .DATA_I_OE_O(oe_i), .DATA_Q_OE_O(oe_q),
        .FORWARDED_OUTPUT_CLOCK_O(fclk), .FORWARDED_OUTPUT_CLOCK_OE_O(fclk_oe),
        .SELFTRIM_ACTIVE_O(st_act), .OUTPUT_SWING_O(swing_o), .ANALOG_ON_O(an_on));
    aoc_capture_model i_aoc_capture_model (.sample_clk_i(smp_clk), .fclk_i(fclk),
        .oe_i(oe_i), .edge_sel_i(edge_sel), .ddr_i(ddr), .data_i_i(d_i), .data_q_i(d_q),
        .cap_i_o(cap_i), .cap_q_o(cap_q), .n_got_o(n_got), .n_bad_o(n_bad),
        .n_tog_o(n_tog), .n_smp_o(n_smp));
    always @(posedge st_act) n_trim++;
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (exp !== got) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
        addr = a;
        cyc(2);
        chk("register read", exp, rdata);
    endtask
    task automatic wait_trim(input logic lvl, output int n);
        n = 0;
        while (st_act !== lvl && n < 20000) begin
            cyc(1);
            n++;
        end
        if (n >= 20000) chk("trim wait", 16'h0000, 16'h0001);
    endtask
    // low then high over 80 sample cycles, normal mode only
    task automatic trim_req;
        req = 1'b0;
        cyc(110);
        req = 1'b1;
        cyc(110);
    endtask
    task automatic send(input logic [7:0] ai, input logic [7:0] aq,
                        input logic [7:0] ei, input logic [7:0] eq);
        int n;
        ain_i = ai;
        ain_q = aq;
        cyc(40);
        exp_q.push_back({ei ^ 8'h80, eq ^ 8'h80});
        n = 0;
        while (exp_q.size() > 0 && n < 500) begin
            cyc(1);
            n++;
        end
        if (n >= 500) chk("capture wait", 16'h0000, 16'h0001);
        chk("newer words", {ei ^ 8'h80, eq ^ 8'h80}, {d_id, d_qd});
    endtask
    task automatic rate_chk(input logic dd);
        int t0;
        int s0;
        int dt;
        int ds;
        t0 = n_tog;
        s0 = n_smp;
        cyc(240);
        dt = n_tog - t0;
        ds = n_smp - s0;
        if (dd) ds = ds / 2;
        chk("clock rate", 16'h0001, 16'((dt - ds <= 2) && (ds - dt <= 2)));
    endtask
    always @(n_got) begin
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk("captured words", e, {cap_i, cap_q});
        end
    end
    initial begin
        // tests need about 16000 core cycles; this leaves more than twice that
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h84bc));
        cyc(8);
        rst_n = 1'b1;
        wait_trim(1'b1, cnt);
        chk("long delay", 16'h0001, 16'(cnt >= 60 && cnt <= 200));
        chk("trim enables", 16'h0000, 16'({oe_i, oe_q, fclk_oe}));
        wait_trim(1'b0, cnt);
        chk("analog on", 16'h0001, {15'h0000, an_on});
        chk("swing", 16'h0001, {15'h0000, swing_o});
        swing = 1'b0;
        cyc(10);
        chk("swing", 16'h0000, {15'h0000, swing_o});
        rreg(IE_ADDR, 16'h0000);
        rreg(4'h3, 16'h0000);
        wreg(IE_ADDR, 16'ha003);
        rreg(IE_ADDR, 16'ha000);
        wreg(IE_ADDR, 16'h0000);
        for (int m = 0; m < 3; m++) begin
            edge_sel = (m == 0);
            ddr = (m == 2);
            cyc(20);
            rate_chk(m == 2);
            foreach (tv[k]) send(tv[k], ~tv[k], tv[k], ~tv[k]);
            rv = 8'($urandom);
            send(rv, rv + 8'h11, rv, rv + 8'h11);
            chk("edge", 16'h0000, 16'(n_bad));
        end
        sleep = 1'b1;
        cyc(20);
        chk("sleep enables", 16'h0005, 16'({oe_i, oe_q, fclk_oe}));
        sleep = 1'b0;
        pd = 1'b1;
        cyc(20);
        chk("down enables", 16'h0000, 16'({oe_i, oe_q, fclk_oe}));
        rreg(IE_ADDR, 16'h0001);
        t = n_trim;
        trim_req();
        chk("trim while down", 16'(t), 16'(n_trim));
        pd = 1'b0;
        cyc(20);
        send(8'h33, 8'hc4, 8'h33, 8'hc4);
        trim_req();
        wait_trim(1'b1, cnt);
        pd = 1'b1;
        cyc(20);
        chk("trim holds", 16'h0001, {15'h0000, st_act});
        wait_trim(1'b0, cnt);
        cyc(10);
        rreg(IE_ADDR, 16'h0001);
        flt = 1'b1; // delay pin was driven high until now
        rst_n = 1'b0;
        cyc(8);
        rst_n = 1'b1;
        cyc(200);
        chk("trim held off", 16'h0000, {15'h0000, st_act});
        pd = 1'b0;
        wait_trim(1'b1, cnt);
        chk("short delay", 16'h0001, 16'(cnt >= 1000 && cnt <= 1150));
        wait_trim(1'b0, cnt);
        send(8'h21, 8'h9e, 8'h21, 8'h21);
        flt = 1'b0;
        ext = 1'b1;
        wreg(IE_ADDR, 16'ha000);
        send(8'h44, 8'hb7, 8'hb7, 8'hb7);
        tally_and_finish();
    end
endmodule // aoc_top_tb
